/* rtl/gtc_pkg.sv */
package gtc_pkg;

    // bus geometry
    localparam int unsigned ADDR_W = 8;                 // apb address width
    localparam int unsigned DATA_W = 32;                // apb data width
    localparam int unsigned CNT_W  = 16;                // counter pair width
    localparam int unsigned PS_W   = 3;                 // prescale counter width

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_TIMER_CONTROL = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_GATE_CONTROL  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_COUNTER_PAIR  = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS    = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK      = 8'h10;

    // timer_control fields
    localparam int unsigned TC_TIMER_ON   = 0;          // count enable
    localparam int unsigned TC_SYNC_BYP   = 2;          // skip resampling
    localparam int unsigned TC_LP_OSC     = 3;          // oscillator enable, stored only
    localparam int unsigned TC_PS_LO      = 4;          // input_prescale low bit
    localparam int unsigned TC_CS_LO      = 6;          // clock source, stored only
    localparam logic [7:0]  TC_WMASK      = 8'hfd;      // bit 1 reads zero

    // gate_control fields
    localparam int unsigned GC_SRC_LO     = 0;          // gate_source_select, stored only
    localparam int unsigned GC_LEVEL      = 2;          // gate_level, read only
    localparam int unsigned GC_ARM_DONE   = 3;          // single_pulse_arm_done
    localparam int unsigned GC_SP_SEL     = 4;          // single_pulse_select
    localparam int unsigned GC_TOGGLE     = 5;          // gate_toggle_select
    localparam int unsigned GC_POLARITY   = 6;          // gate_polarity
    localparam int unsigned GC_ENABLE     = 7;          // gate_enable
    localparam logic [7:0]  GC_WMASK      = 8'hf3;      // stored bits

    // interrupt status bits
    localparam int unsigned IRQ_W         = 2;
    localparam int unsigned IRQ_OVF       = 0;          // counter wrapped
    localparam int unsigned IRQ_GATE_DONE = 1;          // acquisition finished

    // reset values
    localparam logic [7:0]       RST_CTRL  = 8'h00;
    localparam logic [CNT_W-1:0] RST_COUNT = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_ONE   = 16'h0001;
    localparam logic [CNT_W-1:0] CNT_MAX   = 16'hffff;
    localparam logic [PS_W-1:0]  PS_ONE    = 3'h1;

    // prescale limits, divide by 1, 2, 4, 8
    localparam logic [PS_W-1:0]  PS_LIM_1  = 3'h0;
    localparam logic [PS_W-1:0]  PS_LIM_2  = 3'h1;
    localparam logic [PS_W-1:0]  PS_LIM_4  = 3'h3;
    localparam logic [PS_W-1:0]  PS_LIM_8  = 3'h7;

    // map input_prescale code to last prescaler value
    function automatic logic [PS_W-1:0] gtc_ps_limit(input logic [1:0] code);
        case (code)
            2'h3:    return PS_LIM_8;
            2'h2:    return PS_LIM_4;
            2'h1:    return PS_LIM_2;
            default: return PS_LIM_1;
        endcase
    endfunction

endpackage

/* rtl/gtc_in_if.sv */
`timescale 1ns/1ps
// carries the resampled pin events from the input stage to the core
interface gtc_in_if;
    logic count_tick;                                   // one-cycle rising edge of count clock
    logic gate_sync;                                    // resampled raw gate pin
    logic sync_bypass;                                  // select unresampled count clock path
    modport src (output count_tick, output gate_sync, input sync_bypass);
    modport dst (input count_tick, input gate_sync, output sync_bypass);
endinterface

/* rtl/gtc_input_stage.sv */
`timescale 1ns/1ps
// resamples count clock and gate pins into the pclk domain
module gtc_input_stage (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic count_clk_pin,
    input  wire logic gate_pin,
    gtc_in_if.src     port_o
);

    // all state of the stage
    typedef struct packed {
        logic [2:0] ck_sync;                            // count clock chain
        logic       ck_stable;                          // agreed count clock level
        logic       ck_stable_q;                        // previous agreed level
        logic       byp_reg;                            // single capture for bypass path
        logic       byp_prev;                           // previous capture
        logic [2:0] gt_sync;                            // gate chain
        logic       gt_stable;                          // agreed gate level
    } gtc_in_s;

    gtc_in_s st_reg;
    gtc_in_s st_next;

    // chains shift, level accepted once second and third agree
    always_comb
    begin
        st_next             = st_reg;
        st_next.ck_sync     = {st_reg.ck_sync[1:0], count_clk_pin};
        st_next.gt_sync     = {st_reg.gt_sync[1:0], gate_pin};
        st_next.ck_stable_q = st_reg.ck_stable;
        st_next.byp_reg     = count_clk_pin;
        st_next.byp_prev    = st_reg.byp_reg;
        // only stages two and three are compared
        if (st_reg.ck_sync[1] == st_reg.ck_sync[2])
        begin
            st_next.ck_stable = st_reg.ck_sync[2];
        end
        if (st_reg.gt_sync[1] == st_reg.gt_sync[2])
        begin
            st_next.gt_stable = st_reg.gt_sync[2];
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // rising edge on the selected path
    assign port_o.count_tick = port_o.sync_bypass ? (st_reg.byp_reg & ~st_reg.byp_prev)
                                                  : (st_reg.ck_stable & ~st_reg.ck_stable_q);
    assign port_o.gate_sync  = st_reg.gt_stable;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_sync_tick;
        !port_o.sync_bypass && port_o.count_tick
            |-> $past(st_reg.ck_sync[2]) && $past(st_reg.ck_sync[1]) && !$past(st_reg.ck_stable);
    endproperty
    a_sync_tick: assert property (p_sync_tick) else $error("resampled tick without agreed edge");

    property p_byp_tick;
        port_o.sync_bypass && port_o.count_tick |-> $past(count_clk_pin) && !$past(count_clk_pin, 2);
    endproperty
    a_byp_tick: assert property (p_byp_tick) else $error("bypass tick not from raw pin edge");

endmodule // gtc_input_stage

/* rtl/gtc_top.sv */
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - resample count clock unless bypass set
// - bypass set passes count clock unresampled
// - timer_on bit zero gates all counting
// - polarity picks high or low counting level
// - arm/done reads one only while waiting
// - gate_level bit shows applied gate state
// - gate_level updates whatever gate_enable says
// - software arms, gate_level fall clears arm
// - prescale codes divide by 1,2,4,8
module gtc_top (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [gtc_pkg::ADDR_W-1:0]  paddr,
    input  wire logic [gtc_pkg::DATA_W-1:0]  pwdata,
    output logic      [gtc_pkg::DATA_W-1:0]  prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        count_clk_pin,
    input  wire logic                        gate_pin,
    output logic                             irq
);

    // all state of the core
    typedef struct packed {
        logic [7:0]                      tctl;          // timer_control
        logic [7:0]                      gctl;          // gate_control stored bits
        logic                            armed;         // single_pulse_arm_done
        logic                            sp_open;       // single pulse window opened
        logic                            toggle_ff;     // toggle mode flip-flop
        logic                            base_q;        // previous polarity-adjusted gate
        logic                            level_q;       // previous gate_level
        logic [gtc_pkg::PS_W-1:0]        ps_cnt;        // prescaler
        logic [gtc_pkg::CNT_W-1:0]       count;         // counter_pair
        logic [gtc_pkg::IRQ_W-1:0]       status;        // sticky events
        logic [gtc_pkg::IRQ_W-1:0]       mask;          // interrupt mask
        logic [gtc_pkg::DATA_W-1:0]      rdata;         // registered read data
    } gtc_core_s;

    gtc_core_s st_reg;
    gtc_core_s st_next;

    gtc_in_if in_bus ();                                // input stage link

    // pin resampling
    gtc_input_stage u_input (
        .pclk          (pclk),
        .presetn       (presetn),
        .count_clk_pin (count_clk_pin),
        .gate_pin      (gate_pin),
        .port_o        (in_bus.src)
    );

    // decoded fields
    logic       timer_on;                               // counting allowed
    logic       gate_enable;                            // gate controls counting
    logic       gate_pol;                               // counting level
    logic       sp_sel;                                 // single pulse mode
    logic       tog_sel;                                // toggle mode
    logic       gate_base;                              // gate after polarity
    logic       gate_level;                             // gate applied to counter
    logic       level_fall;                             // gate_level falling edge
    logic       count_en;                               // counter may advance
    logic       ps_wrap;                                // prescaler output pulse
    logic       wr_stb;                                 // write access phase
    logic       rd_setup;                               // read setup phase
    logic       addr_hit;                               // mapped address
    logic [gtc_pkg::PS_W-1:0] ps_lim;                   // prescaler last value
    logic [gtc_pkg::IRQ_W-1:0] irq_ev;                  // events raised this cycle

    assign timer_on    = st_reg.tctl[gtc_pkg::TC_TIMER_ON];
    assign gate_enable = st_reg.gctl[gtc_pkg::GC_ENABLE];
    assign gate_pol    = st_reg.gctl[gtc_pkg::GC_POLARITY];
    assign sp_sel      = st_reg.gctl[gtc_pkg::GC_SP_SEL];
    assign tog_sel     = st_reg.gctl[gtc_pkg::GC_TOGGLE];
    assign in_bus.sync_bypass = st_reg.tctl[gtc_pkg::TC_SYNC_BYP];

    // polarity: high counts when bit set, low counts when clear
    assign gate_base = gate_pol ? in_bus.gate_sync : ~in_bus.gate_sync;

    // applied gate: toggle flop, single pulse window, or plain level
    always_comb
    begin
        if (tog_sel)
        begin
            gate_level = st_reg.toggle_ff;
        end
        else
        begin
            gate_level = gate_base;
        end
        if (sp_sel)
        begin
            gate_level = gate_level & st_reg.sp_open;
        end
    end

    assign level_fall = st_reg.level_q & ~gate_level;

    // gate only matters while timer on
    assign count_en = timer_on & (~gate_enable | gate_level);
    assign ps_lim   = gtc_pkg::gtc_ps_limit(st_reg.tctl[gtc_pkg::TC_PS_LO +: 2]);
    assign ps_wrap  = count_en & in_bus.count_tick & (st_reg.ps_cnt == ps_lim);

    // apb decode
    always_comb
    begin
        case (paddr)
            gtc_pkg::OFS_TIMER_CONTROL,
            gtc_pkg::OFS_GATE_CONTROL,
            gtc_pkg::OFS_COUNTER_PAIR,
            gtc_pkg::OFS_IRQ_STATUS,
            gtc_pkg::OFS_IRQ_MASK:   addr_hit = 1'b1;
            default:                 addr_hit = 1'b0;
        endcase
    end

    assign wr_stb   = psel & penable & pwrite & addr_hit;
    assign rd_setup = psel & ~penable & ~pwrite;

    // next state
    always_comb
    begin
        st_next          = st_reg;
        st_next.base_q   = gate_base;
        st_next.level_q  = gate_level;
        irq_ev           = '0;

        // toggle flop follows rising edges of the adjusted gate
        if (!tog_sel)
        begin
            st_next.toggle_ff = 1'b0;
        end
        else if (gate_base && !st_reg.base_q)
        begin
            st_next.toggle_ff = ~st_reg.toggle_ff;
        end

        // window opens on a rising edge while armed
        if (st_reg.armed && gate_base && !st_reg.base_q)
        begin
            st_next.sp_open = 1'b1;
        end

        // hardware clear of arm on falling gate_level
        if (st_reg.armed && level_fall)
        begin
            st_next.armed   = 1'b0;
            st_next.sp_open = 1'b0;
            irq_ev[gtc_pkg::IRQ_GATE_DONE] = 1'b1;
        end

        // prescaler and counter
        if (count_en && in_bus.count_tick)
        begin
            if (ps_wrap)
            begin
                st_next.ps_cnt = '0;
                st_next.count  = st_reg.count + gtc_pkg::CNT_ONE;
                if (st_reg.count == gtc_pkg::CNT_MAX)
                begin
                    irq_ev[gtc_pkg::IRQ_OVF] = 1'b1;
                end
            end
            else
            begin
                st_next.ps_cnt = st_reg.ps_cnt + gtc_pkg::PS_ONE;
            end
        end

        st_next.status = st_reg.status | irq_ev;                    // sticky events

        // register writes
        if (wr_stb)
        begin
            case (paddr)
                gtc_pkg::OFS_TIMER_CONTROL:
                begin
                    st_next.tctl   = pwdata[7:0] & gtc_pkg::TC_WMASK;
                    st_next.ps_cnt = '0;                            // restart division
                end
                gtc_pkg::OFS_GATE_CONTROL:
                begin
                    st_next.gctl = pwdata[7:0] & gtc_pkg::GC_WMASK;
                    // software set beats a same-cycle hardware clear
                    if (pwdata[gtc_pkg::GC_ARM_DONE])
                    begin
                        st_next.armed   = 1'b1;
                        st_next.sp_open = 1'b0;
                    end
                    else
                    begin
                        st_next.armed   = 1'b0;
                        st_next.sp_open = 1'b0;
                    end
                end
                gtc_pkg::OFS_COUNTER_PAIR:
                begin
                    st_next.count  = pwdata[gtc_pkg::CNT_W-1:0];
                    st_next.ps_cnt = '0;
                end
                gtc_pkg::OFS_IRQ_STATUS:
                begin
                    // write one clears, unless the event repeats now
                    st_next.status = (st_reg.status & ~pwdata[gtc_pkg::IRQ_W-1:0]) | irq_ev;
                end
                gtc_pkg::OFS_IRQ_MASK:
                begin
                    st_next.mask = pwdata[gtc_pkg::IRQ_W-1:0];
                end
                default:
                begin
                    st_next.mask = st_reg.mask;
                end
            endcase
        end

        // read data captured in setup, stable through access
        if (rd_setup)
        begin
            st_next.rdata = '0;
            case (paddr)
                gtc_pkg::OFS_TIMER_CONTROL: st_next.rdata[7:0] = st_reg.tctl;
                gtc_pkg::OFS_GATE_CONTROL:
                begin
                    st_next.rdata[7:0] = st_reg.gctl;
                    st_next.rdata[gtc_pkg::GC_ARM_DONE] = st_reg.armed;
                    st_next.rdata[gtc_pkg::GC_LEVEL]    = gate_level;
                end
                gtc_pkg::OFS_COUNTER_PAIR:  st_next.rdata[gtc_pkg::CNT_W-1:0] = st_reg.count;
                gtc_pkg::OFS_IRQ_STATUS:    st_next.rdata[gtc_pkg::IRQ_W-1:0] = st_reg.status;
                gtc_pkg::OFS_IRQ_MASK:      st_next.rdata[gtc_pkg::IRQ_W-1:0] = st_reg.mask;
                default:                    st_next.rdata = '0;
            endcase
        end
    end

    // state register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            st_reg      <= '0;
            st_reg.tctl <= gtc_pkg::RST_CTRL;
            st_reg.gctl <= gtc_pkg::RST_CTRL;
            st_reg.count <= gtc_pkg::RST_COUNT;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // outputs
    assign prdata  = st_reg.rdata;
    assign pready  = 1'b1;                                  // zero wait states
    assign pslverr = psel & penable & ~addr_hit;
    assign irq     = |(st_reg.status & st_reg.mask);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // software write to the counter this cycle
    logic cnt_wr;
    assign cnt_wr = wr_stb && (paddr == gtc_pkg::OFS_COUNTER_PAIR);

    property p_off_holds;
        !timer_on && !cnt_wr |=> $stable(st_reg.count);
    endproperty
    a_off_holds: assert property (p_off_holds) else $error("counter moved while timer off");

    property p_gate_holds;
        timer_on && gate_enable && !gate_level && !cnt_wr |=> $stable(st_reg.count);
    endproperty
    a_gate_holds: assert property (p_gate_holds) else $error("counter moved outside gate");

    property p_ungated_counts;
        timer_on && !gate_enable && in_bus.count_tick && ps_lim == st_reg.ps_cnt && !cnt_wr
            |=> st_reg.count == $past(st_reg.count) + gtc_pkg::CNT_ONE;
    endproperty
    a_ungated_counts: assert property (p_ungated_counts) else $error("gate blocked count while disabled");

    property p_polarity;
        !tog_sel && !sp_sel |-> gate_level == (gate_pol ? in_bus.gate_sync : !in_bus.gate_sync);
    endproperty
    a_polarity: assert property (p_polarity) else $error("gate level ignores polarity");

    property p_ps_step;
        st_reg.count != $past(st_reg.count) && !$past(cnt_wr) |-> $past(st_reg.ps_cnt) == $past(ps_lim);
    endproperty
    a_ps_step: assert property (p_ps_step) else $error("count stepped before prescaler wrapped");

    // arm then falling gate level
    sequence s_armed_fall;
        st_reg.armed && level_fall && !(wr_stb && paddr == gtc_pkg::OFS_GATE_CONTROL);
    endsequence
    sequence s_done;
        !st_reg.armed && st_reg.status[gtc_pkg::IRQ_GATE_DONE];
    endsequence
    property p_arm_clear;
        s_armed_fall |=> s_done;
    endproperty
    a_arm_clear: assert property (p_arm_clear) else $error("arm not cleared on gate fall");

    property p_arm_only_on_fall;
        $fell(st_reg.armed) |-> $past(level_fall) || $past(wr_stb);
    endproperty
    a_arm_only_on_fall: assert property (p_arm_only_on_fall) else $error("arm dropped without cause");

    // read of gate_control in setup shows live level in access
    sequence s_gc_read;
        rd_setup && paddr == gtc_pkg::OFS_GATE_CONTROL;
    endsequence
    property p_level_read;
        s_gc_read |=> prdata[gtc_pkg::GC_LEVEL] == $past(gate_level) &&
                      prdata[gtc_pkg::GC_ARM_DONE] == $past(st_reg.armed);
    endproperty
    a_level_read: assert property (p_level_read) else $error("gate level bit not live");

    property p_irq;
        irq == |(st_reg.status & st_reg.mask);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt disagrees with status and mask");

    // an event in the clearing cycle still leaves its bit set
    property p_set_wins;
        (|irq_ev) |=> (st_reg.status & $past(irq_ev)) == $past(irq_ev);
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("event lost in clearing cycle");

endmodule // gtc_top

/* dv/testbench.sv */
`timescale 1ns/1ps
// self-checking bench for the gated timer control block
module testbench;
    logic                          pclk;           // system clock
    logic                          presetn;        // async reset, active low
    logic                          psel;           // apb select
    logic                          penable;        // apb access phase
    logic                          pwrite;         // apb direction
    logic [gtc_pkg::ADDR_W-1:0]    paddr;          // apb address
    logic [gtc_pkg::DATA_W-1:0]    pwdata;         // apb write data
    logic [gtc_pkg::DATA_W-1:0]    prdata;         // apb read data
    logic                          pready;         // apb ready
    logic                          pslverr;        // apb error
    logic                          count_clk_pin;  // count clock pin
    logic                          gate_pin;       // gate pin
    logic                          irq;            // interrupt line
    int                            bad_count;      // mismatches seen
    int                            total_checks;   // comparisons made
    logic [31:0]                   rd;             // last read word
    logic                          err;            // last error flag
    int                            n;              // pulse count
    logic [1:0]                    code;           // prescale code
    logic                          ge;             // gate enable choice
    logic                          pol;            // polarity choice
    logic                          gp;             // gate pin choice

    gtc_top gtc_top_i (
        .pclk          (pclk),
        .presetn       (presetn),
        .psel          (psel),
        .penable       (penable),
        .pwrite        (pwrite),
        .paddr         (paddr),
        .pwdata        (pwdata),
        .prdata        (prdata),
        .pready        (pready),
        .pslverr       (pslverr),
        .count_clk_pin (count_clk_pin),
        .gate_pin      (gate_pin),
        .irq           (irq)
    );

    // free running 20 mhz clock
    initial
    begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end

    // verdict and end of run
    task automatic complete_run();
        if (bad_count == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // compare one value, report at once
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        // pready ends the wait, only the watchdog ends a hung one
        while (pready !== 1'b1)
        begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // read a register and compare
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(nm, exp, rd);
    endtask

    // interrupt line after writes settle
    task automatic ichk(input logic exp);
        @(posedge pclk);
        #1;
        check("irq", {31'h0, exp}, {31'h0, irq});
    endtask

    // count clock pulses, four cycles high and low
    task automatic pulse(input int k);
        repeat (k)
        begin
            repeat (4) @(posedge pclk);
            count_clk_pin <= 1'b1;
            repeat (4) @(posedge pclk);
            count_clk_pin <= 1'b0;
        end
        repeat (10) @(posedge pclk);
    endtask

    // expected gate_control read word
    function automatic logic [31:0] exp_gc(logic e, logic p, logic arm, logic lvl);
        return {24'h0, e, p, 2'b00, arm, lvl, 2'b00};
    endfunction

    // watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        complete_run();
    end

    // main sequence
    initial
    begin
        {psel, penable, pwrite, count_clk_pin, gate_pin} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        bad_count = 0;
        total_checks = 0;
        presetn = 1'b0;
        void'($urandom(32'h4038));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // reset contents, level high since gate low and polarity low
        rchk("timer_control", gtc_pkg::OFS_TIMER_CONTROL, 32'h0);
        rchk("gate_control", gtc_pkg::OFS_GATE_CONTROL, exp_gc(0, 0, 0, 1));
        rchk("counter_pair", gtc_pkg::OFS_COUNTER_PAIR, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        check("unmapped error", 32'h1, {31'h0, err});
        // timer off: gate active yet nothing counts
        apb(1'b1, gtc_pkg::OFS_GATE_CONTROL, 32'h80);
        pulse(3);
        rchk("counter off", gtc_pkg::OFS_COUNTER_PAIR, 32'h0);
        // every gate enable, polarity and pin level
        for (int i = 0; i < 8; i++)
        begin
            {ge, pol, gp} = i[2:0];
            apb(1'b1, gtc_pkg::OFS_GATE_CONTROL, exp_gc(ge, pol, 0, 0));
            gate_pin <= gp;
            repeat (8) @(posedge pclk);
            rchk("gate_level", gtc_pkg::OFS_GATE_CONTROL, exp_gc(ge, pol, 0, pol == gp));
            apb(1'b1, gtc_pkg::OFS_COUNTER_PAIR, 32'h0);
            apb(1'b1, gtc_pkg::OFS_TIMER_CONTROL, 32'h1);
            pulse(3);
            rchk("gated count", gtc_pkg::OFS_COUNTER_PAIR, (!ge || pol == gp) ? 32'h3 : 32'h0);
            apb(1'b1, gtc_pkg::OFS_TIMER_CONTROL, 32'h0);
        end
        // every prescale code, random counts and boundary counts, sync path picked at random per pass
        apb(1'b1, gtc_pkg::OFS_GATE_CONTROL, 32'h0);
        for (int k = 0; k < 8; k++)
        begin
            code = k[1:0];
            n = (k < 4) ? $urandom_range(20, 1) : (1 << code) - 1 + (k & 1);
            apb(1'b1, gtc_pkg::OFS_COUNTER_PAIR, 32'h0);
            apb(1'b1, gtc_pkg::OFS_TIMER_CONTROL, {26'h0, code, 1'b0, 1'($urandom), 2'b01});
            pulse(n);
            rchk("prescaled count", gtc_pkg::OFS_COUNTER_PAIR, 32'(n >> code));
        end
        // overflow sets a sticky status bit, masked then unmasked
        apb(1'b1, gtc_pkg::OFS_COUNTER_PAIR, 32'hffff);
        apb(1'b1, gtc_pkg::OFS_TIMER_CONTROL, 32'h1);
        pulse(1);
        rchk("wrapped count", gtc_pkg::OFS_COUNTER_PAIR, 32'h0);
        rchk("status ovf", gtc_pkg::OFS_IRQ_STATUS, 32'h1);
        ichk(1'b0);
        apb(1'b1, gtc_pkg::OFS_IRQ_MASK, 32'h3);
        ichk(1'b1);
        apb(1'b1, gtc_pkg::OFS_IRQ_STATUS, 32'h1);
        ichk(1'b0);
        apb(1'b1, gtc_pkg::OFS_TIMER_CONTROL, 32'h0);
        // arm, then gate high and low ends the acquisition
        gate_pin <= 1'b0;
        // polarity first: its own level fall must not end the acquisition
        apb(1'b1, gtc_pkg::OFS_GATE_CONTROL, 32'h40);
        apb(1'b1, gtc_pkg::OFS_GATE_CONTROL, 32'h48);
        rchk("armed", gtc_pkg::OFS_GATE_CONTROL, exp_gc(0, 1, 1, 0));
        gate_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        rchk("armed high", gtc_pkg::OFS_GATE_CONTROL, exp_gc(0, 1, 1, 1));
        gate_pin <= 1'b0;
        repeat (8) @(posedge pclk);
        rchk("done", gtc_pkg::OFS_GATE_CONTROL, exp_gc(0, 1, 0, 0));
        rchk("status done", gtc_pkg::OFS_IRQ_STATUS, 32'h2);
        ichk(1'b1);
        apb(1'b1, gtc_pkg::OFS_IRQ_STATUS, 32'h2);
        ichk(1'b0);
        rchk("status clear", gtc_pkg::OFS_IRQ_STATUS, 32'h0);
        // single pulse select: window opens on gate rise, fall ends it
        apb(1'b1, gtc_pkg::OFS_GATE_CONTROL, 32'h58);
        gate_pin <= 1'b1;
        repeat (8) @(posedge pclk);
        rchk("pulse window", gtc_pkg::OFS_GATE_CONTROL, exp_gc(0, 1, 1, 1) | 32'h10);
        gate_pin <= 1'b0;
        repeat (8) @(posedge pclk);
        rchk("pulse done", gtc_pkg::OFS_GATE_CONTROL, exp_gc(0, 1, 0, 0) | 32'h10);
        rchk("status pulse", gtc_pkg::OFS_IRQ_STATUS, 32'h2);
        complete_run();
    end
endmodule // testbench
